// *** src/serial_eeprom_program_port.sv ***
// Serial programming port: command decode, address pointer, write latch, memories.
// Assumes the serial clock is idle between frames and meets the command gaps.
`timescale 1ns/1ns
module serial_eeprom_program_port #(
  parameter int BULK_ERASE_CYCLES = prog_port_pkg::BULK_ERASE_CYC,
  parameter int ERASE_PROG_CYCLES = prog_port_pkg::WORD_ERASE_PROG_CYC,
  parameter int PROG_ONLY_CYCLES = prog_port_pkg::WORD_PROG_CYC,
  parameter int ENC_DEPTH = prog_port_pkg::ENC_DEPTH
) (
  // Reference clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Programming pins
  input wire logic i_serial_clock_pin,
  input wire logic i_serial_data_pin,
  output logic o_serial_data_pin_out,
  output logic o_serial_data_pin_oe,
  // Status
  output logic o_prog_busy,
  output logic o_encoder_open,
  output logic [prog_port_pkg::PC_W-1:0] o_address_pointer
);
  typedef enum logic [1:0] {OP_ERASE_PROG, OP_PROG_ONLY, OP_BULK} prog_op_e;

  localparam int ENC_AW = $clog2(ENC_DEPTH);
  localparam int TMR_MAX = (BULK_ERASE_CYCLES > ERASE_PROG_CYCLES) ?
    ((BULK_ERASE_CYCLES > PROG_ONLY_CYCLES) ? BULK_ERASE_CYCLES : PROG_ONLY_CYCLES) :
    ((ERASE_PROG_CYCLES > PROG_ONLY_CYCLES) ? ERASE_PROG_CYCLES : PROG_ONLY_CYCLES);
  localparam int TMR_W = $clog2(TMR_MAX + 1);

  if (BULK_ERASE_CYCLES < 2 || ERASE_PROG_CYCLES < 2 || PROG_ONLY_CYCLES < 2) begin : g_bad_time
    $error("program times must be at least two cycles");
  end
  if (ENC_DEPTH < 2 || ENC_DEPTH > 256 || (ENC_DEPTH & (ENC_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("encoder depth must be a power of two up to 256");
  end

  // Old content ANDed in when the word is not erased first
  function automatic logic [prog_port_pkg::DATA_W-1:0] prog_merge(
    input logic [prog_port_pkg::DATA_W-1:0] old_val,
    input logic [prog_port_pkg::DATA_W-1:0] new_val,
    input logic erase_first);
    return erase_first ? new_val : (old_val & new_val);
  endfunction

  // Link domain
  logic link_rst_ff;
  logic link_cmd_tgl;
  logic link_frame_tgl;
  logic [prog_port_pkg::CMD_W-1:0] link_cmd;
  logic [prog_port_pkg::DATA_W-1:0] link_data;
  logic [2:0] cmd_sync_ff;
  logic [2:0] frame_sync_ff;

  // Core state
  logic [prog_port_pkg::PC_W-1:0] pc_ff;
  logic [prog_port_pkg::DATA_W-1:0] latch_ff;
  logic latch_cfg_ff;
  logic latch_valid_ff;
  logic load_wait_ff;
  logic load_cfg_ff;
  logic bulk_pending_ff;
  logic busy_ff;
  prog_op_e op_ff;
  logic [TMR_W-1:0] timer_ff;
  logic [prog_port_pkg::DATA_W-1:0] rd_word_ff;
  logic enc_open_ff;
  logic [prog_port_pkg::ENC_W-1:0] enc_mem [ENC_DEPTH];
  logic [prog_port_pkg::DATA_W-1:0] cfg_mem [prog_port_pkg::CFG_DEPTH];

  prog_link u_link (
    .i_link_clk(i_serial_clock_pin),
    .i_link_rst(link_rst_ff),
    .i_sdata(i_serial_data_pin),
    .o_sdata_out(o_serial_data_pin_out),
    .o_sdata_oe(o_serial_data_pin_oe),
    .i_rd_word(rd_word_ff),
    .o_cmd_tgl(link_cmd_tgl),
    .o_cmd(link_cmd),
    .o_frame_tgl(link_frame_tgl),
    .o_frame_data(link_data)
  );

  // Link reset is applied while the serial clock stands still
  always_ff @(posedge i_ref_clk) begin
    link_rst_ff <= i_rst;
  end

  // Toggle crossings; stage 0 feeds only stage 1
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cmd_sync_ff <= 3'h0;
      frame_sync_ff <= 3'h0;
    end else begin
      cmd_sync_ff <= {cmd_sync_ff[1:0], link_cmd_tgl};
      frame_sync_ff <= {frame_sync_ff[1:0], link_frame_tgl};
    end
  end

  wire cmd_evt = cmd_sync_ff[2] ^ cmd_sync_ff[1];
  wire frame_evt = frame_sync_ff[2] ^ frame_sync_ff[1];
  // Command word stands still from its toggle to the next command
  wire accept = cmd_evt && !busy_ff;
  wire do_load_cfg = accept && (link_cmd == prog_port_pkg::CMD_LOAD_CFG);
  wire do_load_enc = accept && (link_cmd == prog_port_pkg::CMD_LOAD_ENC);
  wire do_read_cfg = accept && (link_cmd == prog_port_pkg::CMD_READ_CFG);
  wire do_read_enc = accept && (link_cmd == prog_port_pkg::CMD_READ_ENC);
  wire do_inc = accept && (link_cmd == prog_port_pkg::CMD_INC_ADDR);
  wire do_begin_ep = accept && (link_cmd == prog_port_pkg::CMD_ERASE_PROG);
  wire do_begin_po = accept && (link_cmd == prog_port_pkg::CMD_PROG_ONLY);
  wire do_bulk = accept && (link_cmd == prog_port_pkg::CMD_BULK_ERASE);
  wire do_begin = (do_begin_ep || do_begin_po) && (latch_valid_ff || bulk_pending_ff);
  wire undefined_cmd = accept && !(do_load_cfg || do_load_enc || do_read_cfg || do_read_enc ||
                                   do_inc || do_begin_ep || do_begin_po || do_bulk);

  // Address decode
  wire [prog_port_pkg::ENC_SPACE_W-1:0] enc_addr = pc_ff[prog_port_pkg::ENC_SPACE_W-1:0];
  wire enc_hit = ({1'b0, enc_addr} < 9'(ENC_DEPTH));
  wire [ENC_AW-1:0] enc_idx = enc_addr[ENC_AW-1:0];
  wire cfg_hit = (pc_ff < 10'(prog_port_pkg::CFG_DEPTH));
  wire [prog_port_pkg::CFG_AW-1:0] cfg_idx = pc_ff[prog_port_pkg::CFG_AW-1:0];
  wire [prog_port_pkg::DATA_W-1:0] cfg_cur = cfg_mem[cfg_idx];
  wire [prog_port_pkg::DATA_W-1:0] cfg_word = cfg_mem[prog_port_pkg::CFG_WORD_ADDR[prog_port_pkg::CFG_AW-1:0]];
  wire protect_n = cfg_word[prog_port_pkg::PROTECT_BIT];
  wire enc_readable = protect_n && enc_hit;

  wire [prog_port_pkg::DATA_W-1:0] rd_cfg_val = cfg_hit ? cfg_cur : 12'h000;
  wire [prog_port_pkg::DATA_W-1:0] rd_enc_val = enc_readable ? {4'h0, enc_mem[enc_idx]} : 12'h000;

  // Programming commit
  wire commit = busy_ff && (timer_ff == TMR_W'(1));
  wire erase_first = (op_ff == OP_ERASE_PROG);
  wire cfg_target = (op_ff != OP_BULK) && latch_cfg_ff && cfg_hit;
  wire cfg_is_word = cfg_target && (pc_ff == prog_port_pkg::CFG_WORD_ADDR);
  wire ep_new = latch_ff[prog_port_pkg::PROTECT_BIT];
  wire ep_differs = ep_new != cfg_cur[prog_port_pkg::PROTECT_BIT];
  wire [prog_port_pkg::DATA_W-1:0] cfg_merged = prog_merge(cfg_cur, latch_ff, erase_first);
  wire cfg_write = commit && cfg_target && (!cfg_is_word || ep_differs);
  // Judged on the merged word: a program-only cycle cannot raise the bit
  wire unprotect = cfg_write && cfg_is_word && cfg_merged[prog_port_pkg::PROTECT_BIT] &&
                   !cfg_cur[prog_port_pkg::PROTECT_BIT];
  wire bulk_all = (commit && op_ff == OP_BULK) || unprotect;
  wire enc_write = commit && (op_ff != OP_BULK) && !latch_cfg_ff && protect_n && enc_hit;
  wire [prog_port_pkg::DATA_W-1:0] enc_merged =
    prog_merge({4'h0, enc_mem[enc_idx]}, latch_ff, erase_first);

  wire [TMR_W-1:0] start_time = bulk_pending_ff ? TMR_W'(BULK_ERASE_CYCLES) :
                                do_begin_ep ? TMR_W'(ERASE_PROG_CYCLES) : TMR_W'(PROG_ONLY_CYCLES);
  prog_op_e start_op;
  assign start_op = bulk_pending_ff ? OP_BULK : (do_begin_ep ? OP_ERASE_PROG : OP_PROG_ONLY);

  // Address pointer
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pc_ff <= prog_port_pkg::PC_ENTRY;
    end else if (do_load_cfg) begin
      pc_ff <= prog_port_pkg::PC_ENTRY;
    end else if (do_inc) begin
      pc_ff <= pc_ff + 10'h001;
    end
  end

  // Write latch, filled by the frame that follows a load
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      latch_ff <= 12'h000;
      latch_cfg_ff <= 1'b0;
      latch_valid_ff <= 1'b0;
      load_wait_ff <= 1'b0;
      load_cfg_ff <= 1'b0;
    end else begin
      if (do_load_cfg || do_load_enc) begin
        load_wait_ff <= 1'b1;
        load_cfg_ff <= do_load_cfg;
      end else if (frame_evt || accept) begin
        load_wait_ff <= 1'b0;
      end
      if (frame_evt && load_wait_ff) begin
        latch_ff <= load_cfg_ff ? link_data : {4'h0, link_data[prog_port_pkg::ENC_W-1:0]};
        latch_cfg_ff <= load_cfg_ff;
        latch_valid_ff <= 1'b1;
      end else if (do_begin) begin
        latch_valid_ff <= 1'b0;
      end
    end
  end

  // Read word held for the link until the next read
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rd_word_ff <= 12'h000;
    end else if (do_read_cfg) begin
      rd_word_ff <= rd_cfg_val;
    end else if (do_read_enc) begin
      rd_word_ff <= rd_enc_val;
    end
  end

  // Self-timed cycle; commands arriving while busy are dropped
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      busy_ff <= 1'b0;
      timer_ff <= '0;
      op_ff <= OP_ERASE_PROG;
      bulk_pending_ff <= 1'b0;
    end else begin
      if (do_begin) begin
        busy_ff <= 1'b1;
        timer_ff <= start_time;
        op_ff <= start_op;
      end else if (busy_ff) begin
        timer_ff <= timer_ff - TMR_W'(1);
        busy_ff <= !commit;
      end
      if (do_bulk) begin
        bulk_pending_ff <= 1'b1;
      end else if (commit && op_ff == OP_BULK) begin
        bulk_pending_ff <= 1'b0;
      end
    end
  end

  // Encoder array; reset stands in for the stored image
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      for (int i = 0; i < ENC_DEPTH; i++) begin
        enc_mem[i] <= prog_port_pkg::ENC_ERASED;
      end
    end else if (bulk_all) begin
      for (int i = 0; i < ENC_DEPTH; i++) begin
        enc_mem[i] <= prog_port_pkg::ENC_ERASED;
      end
    end else if (enc_write) begin
      enc_mem[enc_idx] <= enc_merged[prog_port_pkg::ENC_W-1:0];
    end
  end

  // Configuration array
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      for (int i = 0; i < prog_port_pkg::CFG_DEPTH; i++) begin
        cfg_mem[i] <= prog_port_pkg::CFG_INIT;
      end
    end else if (cfg_write) begin
      cfg_mem[cfg_idx] <= cfg_merged;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      enc_open_ff <= 1'b0;
    end else begin
      enc_open_ff <= protect_n;
    end
  end

  assign o_prog_busy = busy_ff;
  assign o_encoder_open = enc_open_ff;
  assign o_address_pointer = pc_ff;

  property p_load_cfg_pc;
    @(posedge i_ref_clk) disable iff (i_rst)
    do_load_cfg |=> (pc_ff == prog_port_pkg::PC_ENTRY);
  endproperty
  a_load_cfg_pc: assert property (p_load_cfg_pc) else $error("load-config did not set the pointer to 3FFh");

  property p_inc;
    @(posedge i_ref_clk) disable iff (i_rst)
    do_inc |=> (pc_ff == $past(pc_ff) + 10'h001);
  endproperty
  a_inc: assert property (p_inc) else $error("increment did not add one");

  property p_protect_read;
    @(posedge i_ref_clk) disable iff (i_rst)
    (do_read_enc && !protect_n) |=> (rd_word_ff == 12'h000);
  endproperty
  a_protect_read: assert property (p_protect_read) else $error("protected encoder read not zero");

  property p_enc_pad;
    @(posedge i_ref_clk) disable iff (i_rst)
    do_read_enc |=> (rd_word_ff[11:8] == 4'h0) && (rd_word_ff == $past(rd_enc_val));
  endproperty
  a_enc_pad: assert property (p_enc_pad) else $error("encoder read padding wrong");

  property p_unmapped;
    @(posedge i_ref_clk) disable iff (i_rst)
    (do_read_enc && enc_addr >= 8'h40) |=> (rd_word_ff == 12'h000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unimplemented encoder address not zero");

  property p_cfg_read;
    @(posedge i_ref_clk) disable iff (i_rst)
    (do_read_cfg && pc_ff == 10'h000) |=> (rd_word_ff == $past(cfg_word));
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("configuration read blocked or wrong");

  property p_undefined;
    @(posedge i_ref_clk) disable iff (i_rst)
    (undefined_cmd && !frame_evt) |=> $stable(pc_ff) && $stable(latch_ff) && !busy_ff;
  endproperty
  a_undefined: assert property (p_undefined) else $error("undefined command changed state");

  property p_bulk_result;
    @(posedge i_ref_clk) disable iff (i_rst)
    bulk_all |=> (enc_mem[0] == 8'hff) && (enc_mem[ENC_DEPTH-1] == 8'hff);
  endproperty
  a_bulk_result: assert property (p_bulk_result) else $error("bulk erase left a location not 0FFh");

  property p_cfg_same_ep;
    @(posedge i_ref_clk) disable iff (i_rst)
    (commit && cfg_is_word && !ep_differs) |=> $stable(cfg_word);
  endproperty
  a_cfg_same_ep: assert property (p_cfg_same_ep) else $error("config word changed without protect change");

  property p_busy_time;
    @(posedge i_ref_clk) disable iff (i_rst)
    (do_begin && bulk_pending_ff) |=> busy_ff [*2] ##0 (op_ff == OP_BULK);
  endproperty
  a_busy_time: assert property (p_busy_time) else $error("bulk erase cycle not started");

  // Protect and write-path checks
  property p_unprotect_erase;
    @(posedge i_ref_clk) disable iff (i_rst)
    unprotect |=> protect_n && (enc_mem[0] == prog_port_pkg::ENC_ERASED) &&
                  (enc_mem[ENC_DEPTH-1] == prog_port_pkg::ENC_ERASED);
  endproperty
  a_unprotect_erase: assert property (p_unprotect_erase) else $error("protect lift did not erase encoder memory");

  property p_enc_write_lands;
    @(posedge i_ref_clk) disable iff (i_rst)
    (enc_write && erase_first) |=>
      ({4'h0, enc_mem[$past(enc_idx)]} == $past(latch_ff));
  endproperty
  a_enc_write_lands: assert property (p_enc_write_lands) else $error("encoder word not written with latch");

  property p_protect_write;
    @(posedge i_ref_clk) disable iff (i_rst)
    (commit && !latch_cfg_ff && op_ff != OP_BULK && !protect_n) |=> $stable(enc_mem[enc_idx]);
  endproperty
  a_protect_write: assert property (p_protect_write) else $error("protected encoder word was written");

  property p_load_enc_latch;
    @(posedge i_ref_clk) disable iff (i_rst)
    (frame_evt && load_wait_ff && !load_cfg_ff) |=> (latch_ff == {4'h0, link_data[prog_port_pkg::ENC_W-1:0]});
  endproperty
  a_load_enc_latch: assert property (p_load_enc_latch) else $error("encoder load kept more than 8 bits");

  c_unprotect: cover property (@(posedge i_ref_clk) disable iff (i_rst) unprotect);
  c_bulk_cycle: cover property (@(posedge i_ref_clk) disable iff (i_rst) commit && op_ff == OP_BULK);
  c_enc_write: cover property (@(posedge i_ref_clk) disable iff (i_rst) enc_write);
  c_read_open: cover property (@(posedge i_ref_clk) disable iff (i_rst) do_read_enc && enc_readable);
endmodule // serial_eeprom_program_port

// *** shared/prog_port_pkg.sv ***
// Constants, command codes and timing for the serial EEPROM programming port.
// Assumes a 125 MHz reference clock and a programmer that owns the serial clock pin.
// How it works
// - Load-configuration command sets the address pointer to 3FFh.
// - Configuration load frame is 16 cycles carrying a 12-bit word.
// - Encoder load keeps the first 8 data bits; all 16 cycles still clocked.
// - Encoder uses pointer bits 7:0; 00h-3Fh stored, 40h-FFh read zero.
// - Pointer bits above bit 7 are ignored for the encoder memory.
// - Configuration read shifts the addressed word out from rising edge two.
// - Data pin drives from rising edge two, released at rising edge 16.
// - Configuration reads ignore the protect bit.
// - Encoder read sends 8 data bits, the rest of the frame zero.
// - Protected encoder reads return zero and writes are dropped.
// - Increment command adds one to the address pointer, no frame.
// - Erase-and-program command runs a timed word erase then write.
// - Program-only command writes the latch without erasing first.
// - After bulk-erase command, next program command erases the encoder memory, 10 ms.
// - Configuration word changes only when the new protect bit differs.
// - Bit 6 of the configuration word is the active-low protect bit.
// - Protect bit going 0 to 1 bulk erases the encoder memory.
// - Six-bit commands LSB first on falling edges; framed commands take 16 cycles.
// - Bulk erase leaves every encoder location at 0FFh.
package prog_port_pkg;
  localparam int CMD_W = 6;
  localparam int DATA_W = 12;
  localparam int ENC_W = 8;
  localparam int PC_W = 10;
  localparam int ENC_SPACE_W = 8;
  localparam int CFG_AW = 4;
  localparam int CFG_DEPTH = 16;
  localparam int ENC_DEPTH = 64;
  localparam int PROTECT_BIT = 6;
  localparam logic [5:0] CMD_LOAD_CFG = 6'h00;
  localparam logic [5:0] CMD_LOAD_ENC = 6'h03;
  localparam logic [5:0] CMD_READ_CFG = 6'h04;
  localparam logic [5:0] CMD_READ_ENC = 6'h05;
  localparam logic [5:0] CMD_INC_ADDR = 6'h06;
  localparam logic [5:0] CMD_ERASE_PROG = 6'h08;
  localparam logic [5:0] CMD_PROG_ONLY = 6'h0a;
  localparam logic [5:0] CMD_BULK_ERASE = 6'h0b;
  localparam logic [9:0] PC_ENTRY = 10'h3ff;
  localparam logic [9:0] CFG_WORD_ADDR = 10'h000;
  localparam logic [7:0] ENC_ERASED = 8'hff;
  localparam logic [11:0] CFG_INIT = 12'hfff;
  // Falling-edge counter values inside command and frame
  localparam logic [3:0] CMD_LAST_BIT = 4'h5;
  localparam logic [3:0] FRAME_LAST_BIT = 4'hf;
  localparam logic [3:0] DATA_FIRST_BIT = 4'h1;
  localparam logic [3:0] DATA_LAST_BIT = 4'hc;
  // Rising-edge numbers inside a frame
  localparam logic [4:0] EDGE_FIRST_DATA = 5'h02;
  localparam logic [4:0] EDGE_LAST_DATA = 5'h0d;
  localparam logic [4:0] EDGE_RELEASE = 5'h10;
  // Timing
  localparam int REF_CLK_PERIOD_NS = 8;
  localparam int NS_PER_MS = 1000000;
  localparam int BULK_ERASE_MS = 10;
  localparam int WORD_ERASE_PROG_MS = 4;
  localparam int WORD_PROG_MS = 2;
  localparam int BULK_ERASE_CYC = BULK_ERASE_MS * NS_PER_MS / REF_CLK_PERIOD_NS;
  localparam int WORD_ERASE_PROG_CYC = WORD_ERASE_PROG_MS * NS_PER_MS / REF_CLK_PERIOD_NS;
  localparam int WORD_PROG_CYC = WORD_PROG_MS * NS_PER_MS / REF_CLK_PERIOD_NS;

  function automatic logic has_frame(input logic [CMD_W-1:0] c);
    return (c == CMD_LOAD_CFG) || (c == CMD_LOAD_ENC) || (c == CMD_READ_CFG) || (c == CMD_READ_ENC);
  endfunction
endpackage

// *** src/prog_link.sv ***
// Link-side shifter of the programming port, clocked by the serial clock pin.
// Assumes the core holds i_rd_word steady from rising edge two to frame end.
`timescale 1ns/1ns
module prog_link (
  // Link clock and reset
  input wire logic i_link_clk,
  input wire logic i_link_rst,
  // Data pin
  input wire logic i_sdata,
  output logic o_sdata_out,
  output logic o_sdata_oe,
  // Core side
  input wire logic [prog_port_pkg::DATA_W-1:0] i_rd_word,
  output logic o_cmd_tgl,
  output logic [prog_port_pkg::CMD_W-1:0] o_cmd,
  output logic o_frame_tgl,
  output logic [prog_port_pkg::DATA_W-1:0] o_frame_data
);
  typedef enum logic {LS_CMD, LS_FRAME} link_state_e;

  link_state_e state_ff, nxt_state;
  logic [3:0] bit_cnt_ff;
  logic [prog_port_pkg::CMD_W-1:0] cmd_shift_ff;
  logic [prog_port_pkg::DATA_W-1:0] data_shift_ff;
  logic [4:0] rise_cnt_ff;

  wire cmd_done = (state_ff == LS_CMD) && (bit_cnt_ff == prog_port_pkg::CMD_LAST_BIT);
  wire frame_done = (state_ff == LS_FRAME) && (bit_cnt_ff == prog_port_pkg::FRAME_LAST_BIT);
  wire data_bit = (state_ff == LS_FRAME) && (bit_cnt_ff >= prog_port_pkg::DATA_FIRST_BIT) &&
                  (bit_cnt_ff <= prog_port_pkg::DATA_LAST_BIT);
  wire [prog_port_pkg::CMD_W-1:0] nxt_cmd_shift = {i_sdata, cmd_shift_ff[prog_port_pkg::CMD_W-1:1]};
  wire [prog_port_pkg::DATA_W-1:0] nxt_data_shift =
    data_bit ? {i_sdata, data_shift_ff[prog_port_pkg::DATA_W-1:1]} : data_shift_ff;
  wire [3:0] nxt_bit_cnt = (cmd_done || frame_done) ? 4'h0 : bit_cnt_ff + 4'h1;

  always_comb begin
    nxt_state = state_ff;
    if (cmd_done && prog_port_pkg::has_frame(nxt_cmd_shift)) begin
      nxt_state = LS_FRAME;
    end else if (frame_done) begin
      nxt_state = LS_CMD;
    end
  end

  // Capture on falling edges, LSB first
  always_ff @(negedge i_link_clk or posedge i_link_rst) begin
    if (i_link_rst) begin
      state_ff <= LS_CMD;
      bit_cnt_ff <= 4'h0;
      cmd_shift_ff <= 6'h00;
      data_shift_ff <= 12'h000;
      o_cmd <= 6'h3f;
      o_cmd_tgl <= 1'b0;
      o_frame_tgl <= 1'b0;
      o_frame_data <= 12'h000;
    end else begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      data_shift_ff <= nxt_data_shift;
      if (state_ff == LS_CMD) begin
        cmd_shift_ff <= nxt_cmd_shift;
      end
      if (cmd_done) begin
        o_cmd <= nxt_cmd_shift;
        o_cmd_tgl <= ~o_cmd_tgl;
      end
      // Frame hand-off only on the 16th edge, so short frames never land
      if (frame_done) begin
        o_frame_data <= data_shift_ff;
        o_frame_tgl <= ~o_frame_tgl;
      end
    end
  end

  wire [4:0] nxt_rise = rise_cnt_ff + 5'h01;
  wire [3:0] rise_idx = 4'(nxt_rise - prog_port_pkg::EDGE_FIRST_DATA);
  wire rd_cmd = (o_cmd == prog_port_pkg::CMD_READ_CFG) || (o_cmd == prog_port_pkg::CMD_READ_ENC);
  wire in_data = (nxt_rise >= prog_port_pkg::EDGE_FIRST_DATA) && (nxt_rise <= prog_port_pkg::EDGE_LAST_DATA);
  wire drive = rd_cmd && (nxt_rise >= prog_port_pkg::EDGE_FIRST_DATA) &&
               (nxt_rise < prog_port_pkg::EDGE_RELEASE);

  // Drive on rising edges
  always_ff @(posedge i_link_clk or posedge i_link_rst) begin
    if (i_link_rst) begin
      rise_cnt_ff <= 5'h00;
      o_sdata_oe <= 1'b0;
      o_sdata_out <= 1'b0;
    end else if (state_ff != LS_FRAME) begin
      rise_cnt_ff <= 5'h00;
      o_sdata_oe <= 1'b0;
      o_sdata_out <= 1'b0;
    end else begin
      rise_cnt_ff <= nxt_rise;
      o_sdata_oe <= drive;
      o_sdata_out <= drive && in_data && i_rd_word[rise_idx];
    end
  end

  property p_oe_on_second_edge;
    @(posedge i_link_clk) disable iff (i_link_rst)
    (state_ff == LS_FRAME && rd_cmd && rise_cnt_ff == 5'h01) |=> o_sdata_oe && (o_sdata_out == i_rd_word[0]);
  endproperty
  a_oe_on_second_edge: assert property (p_oe_on_second_edge) else $error("data pin not driven at edge two");

  property p_oe_release;
    @(posedge i_link_clk) disable iff (i_link_rst)
    (rise_cnt_ff == prog_port_pkg::EDGE_RELEASE) |-> !o_sdata_oe;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("data pin still driven after edge 16");

  property p_read_frame; 
    @(posedge i_link_clk) disable iff (i_link_rst)
    (rd_cmd && rise_cnt_ff == prog_port_pkg::EDGE_LAST_DATA);
  endproperty
  c_read_frame: cover property (p_read_frame);
endmodule // prog_link

// *** tb/prog_model.sv ***
// Programmer model: owns the serial clock and drives the data pin outside reads.
// Assumes the device shows its pin drive through i_dev_oe and i_dev_out.
`timescale 1ns/1ns
module prog_model (
  // Serial pins
  output logic o_sclk,
  output logic o_wire,
  // Device pin drive
  input wire logic i_dev_out,
  input wire logic i_dev_oe
);
  logic drv;
  assign o_wire = i_dev_oe ? i_dev_out : drv;
  initial begin
    o_sclk = 1'b0;
    drv = 1'b0;
  end
  // Data set at rise, both sides sample at fall
  task automatic tick(input logic b, output logic s, output logic e);
    o_sclk = 1'b1;
    drv = b;
    #80;
    s = o_wire;
    e = i_dev_oe;
    o_sclk = 1'b0;
    #80;
  endtask
  // Clock parks low in the gap; gap not a clock multiple, so phase drifts
  task automatic cmd(input logic [5:0] c);
    logic s, e;
    for (int i = 0; i < 6; i++) tick(c[i], s, e);
    #1203;
  endtask
  // Released pin has no pull, so a toggling pattern stands in during reads
  task automatic frame(input logic [11:0] d, input logic rd, output logic [15:0] r, output logic [15:0] e);
    logic [15:0] b;
    logic s, x;
    b = {3'h0, d, 1'b0};
    for (int k = 0; k < 16; k++) begin
      tick(rd ? ~k[0] : b[k], s, x);
      r[k] = s;
      e[k] = x;
    end
    #1203;
  endtask
endmodule // prog_model

// *** tb/serial_eeprom_program_port_test.sv ***
// Testbench: programmer command sequences with expected read-back values.
// Assumes shortened self-timed counts; every begin command follows a load or a bulk-erase command.
`timescale 1ns/1ns
module serial_eeprom_program_port_test;
  logic i_ref_clk, i_rst, sclk, sdat, dout, doe, busy, open;
  logic [9:0] ptr;
  int mismatches, samples_checked;
  serial_eeprom_program_port #(.BULK_ERASE_CYCLES(20), .ERASE_PROG_CYCLES(10), .PROG_ONLY_CYCLES(6)) DUT (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_serial_clock_pin(sclk), .i_serial_data_pin(sdat),
    .o_serial_data_pin_out(dout), .o_serial_data_pin_oe(doe), .o_prog_busy(busy),
    .o_encoder_open(open), .o_address_pointer(ptr));
  prog_model m (.o_sclk(sclk), .o_wire(sdat), .i_dev_out(dout), .i_dev_oe(doe));
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic idle;
    for (int n = 0; busy !== 1'b0; n++) begin
      @(negedge i_ref_clk);
      if (n > 300) begin
        check("busy", 16'h1, 16'h0);
        end_of_test();
      end
    end
  endtask
  task automatic rd(input logic [5:0] c, input logic [11:0] exp);
    logic [15:0] r, e;
    m.cmd(c);
    m.frame(12'h000, 1'b1, r, e);
    check("pin enable", e, 16'h7ffe);
    check("read data", {2'b00, r[14:1]}, {4'h0, exp});
  endtask
  // Load then begin; a config load moves the pointer to 3ffh first
  task automatic prog(input logic [5:0] lc, input logic [11:0] d, input logic [5:0] bc);
    logic [15:0] r, e;
    m.cmd(lc);
    m.frame(d, 1'b0, r, e);
    if (lc == prog_port_pkg::CMD_LOAD_CFG) begin
      check("pointer", {6'h0, ptr}, 16'h3ff);
      m.cmd(prog_port_pkg::CMD_INC_ADDR);
    end
    m.cmd(bc);
    idle();
  endtask
  // Counter image: A B C after the pseudo-Gray step, then B^C, A^B, A^C
  task automatic store_counter(input logic [19:0] v);
    logic [7:0] a, b, c;
    logic [47:0] img;
    a = {4'h0, v[19:16]};
    b = v[15:8];
    c = v[7:0];
    if (b[0]) c = c ^ 8'hff;
    if (a[0]) b = b ^ 8'hff;
    img = {a ^ c, a ^ b, b ^ c, c, b, a};
    for (int i = 0; i < 6; i++) begin
      prog(prog_port_pkg::CMD_LOAD_ENC, {4'h0, img[i*8 +: 8]}, prog_port_pkg::CMD_ERASE_PROG);
      rd(prog_port_pkg::CMD_READ_ENC, {4'h0, img[i*8 +: 8]});
      m.cmd(prog_port_pkg::CMD_INC_ADDR);
    end
  endtask
  initial begin
    i_rst = 1'b1;
    mismatches = 0;
    samples_checked = 0;
    repeat (8) @(negedge i_ref_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    m.cmd(prog_port_pkg::CMD_INC_ADDR);
    check("pointer", {6'h0, ptr}, 16'h000);
    rd(prog_port_pkg::CMD_READ_CFG, 12'hfff);
    prog(prog_port_pkg::CMD_LOAD_ENC, 12'h5a5, prog_port_pkg::CMD_ERASE_PROG);
    rd(prog_port_pkg::CMD_READ_ENC, 12'h0a5);
    m.cmd(6'h3f);
    check("pointer", {6'h0, ptr}, 16'h000);
    rd(prog_port_pkg::CMD_READ_ENC, 12'h0a5);
    m.cmd(prog_port_pkg::CMD_BULK_ERASE);
    m.cmd(prog_port_pkg::CMD_ERASE_PROG);
    idle();
    rd(prog_port_pkg::CMD_READ_ENC, 12'h0ff);
    prog(prog_port_pkg::CMD_LOAD_ENC, 12'h0f3, prog_port_pkg::CMD_PROG_ONLY);
    prog(prog_port_pkg::CMD_LOAD_ENC, 12'h03c, prog_port_pkg::CMD_PROG_ONLY);
    rd(prog_port_pkg::CMD_READ_ENC, 12'h030);
    prog(prog_port_pkg::CMD_LOAD_CFG, 12'hfbf, prog_port_pkg::CMD_ERASE_PROG);
    check("open", {15'h0, open}, 16'h0);
    rd(prog_port_pkg::CMD_READ_CFG, 12'hfbf);
    rd(prog_port_pkg::CMD_READ_ENC, 12'h000);
    prog(prog_port_pkg::CMD_LOAD_ENC, 12'h012, prog_port_pkg::CMD_ERASE_PROG);
    prog(prog_port_pkg::CMD_LOAD_CFG, 12'h0bf, prog_port_pkg::CMD_ERASE_PROG);
    rd(prog_port_pkg::CMD_READ_CFG, 12'hfbf);
    prog(prog_port_pkg::CMD_LOAD_CFG, 12'hfff, prog_port_pkg::CMD_ERASE_PROG);
    check("open", {15'h0, open}, 16'h1);
    rd(prog_port_pkg::CMD_READ_ENC, 12'h0ff);
    store_counter(20'hfabcd);
    repeat (64) m.cmd(prog_port_pkg::CMD_INC_ADDR);
    check("pointer", {6'h0, ptr}, 16'h046);
    prog(prog_port_pkg::CMD_LOAD_ENC, 12'h055, prog_port_pkg::CMD_ERASE_PROG);
    rd(prog_port_pkg::CMD_READ_ENC, 12'h000);
    end_of_test();
  end
endmodule // serial_eeprom_program_port_test
